// [expander_pkg.sv]
// Purpose: Shared constants for the serial port expander
// Assumes: Single 10 MHz clock domain
// Notes:   Address-select pin codes follow the pin map
package expander_pkg;
	localparam int         CLK_HZ       = 10_000_000;
	localparam logic [2:0] TOP_IN       = 3'h6;
	localparam logic [2:0] TOP_OUT      = 3'h5;
	localparam logic [3:0] BYTE_BITS    = 4'h8;
	localparam logic [3:0] BIT_ONE      = 4'h1;
	localparam logic [3:0] BIT_ZERO     = 4'h0;
	localparam logic [7:0] MASK_RESET   = 8'hFF;
	localparam logic [7:0] FLAGS_RESET  = 8'h00;
	localparam logic [7:0] BYTE_ZERO    = 8'h00;
	// Code of the high select pin, bits 3..2 of the address
	localparam logic [1:0] HI_SCL       = 2'h0;
	localparam logic [1:0] HI_SDA       = 2'h1;
	localparam logic [1:0] HI_GND       = 2'h2;
	localparam logic [1:0] HI_VPLUS     = 2'h3;
	// Code of the low select pin, bits 1..0 of the address
	localparam logic [1:0] LO_GND       = 2'h0;
	localparam logic [1:0] LO_VPLUS     = 2'h1;
	localparam logic [1:0] LO_SCL       = 2'h2;
	localparam logic [1:0] LO_SDA       = 2'h3;
	localparam int         BYTE_W       = 8;
	typedef enum logic [2:0] {
		st_idle, st_addr, st_aack, st_rx, st_rack, st_tx, st_mack
	} link_state_t;
endpackage

// [port_expander.sv]
// Purpose: Serial-slave port expander, eight sense inputs, eight driven outputs
// Assumes: Bus lines and pins are asynchronous and are synchronised here
// Notes:   Link runs on oversampled SCL and SDA, no second clock domain
//
// What this block does
// - Long input read alternates data and flags, resampling each pair
// - Eight-bit interrupt mask, one bit per sense input
// - Transition flag sets on change regardless of mask
// - Alert held off during a read, raised at stop if pending
// - Changes already sent before stop raise no alert
// - Flags stay set until the next access clears them
// - Start and stop conditions are detected
// - One bit per clock pulse, data stable while clock high
// - Ninth bit acknowledge; device acknowledges received bytes
// - Two addresses: 110 for inputs, 101 for outputs
// - Low four address bits from two four-level select pins
// - Bit after address is direction, high means read
// - One-byte input read returns inputs, clears flags and alert
// - Output reads return sensed output pin levels, every byte
// - Two-byte read clears at address ack but sends old flags
// - Sent input data captured at the preceding acknowledge
// - Input-address write loads mask, clears flags and alert
// - Output-address write sets all outputs, every byte until stop
// - SDA open drain pulling low only, SCL input only
// - Every acknowledge except the one before a flags byte latches snapshot and clears flags
// - Power-on: mask all ones, flags clear, alert off
// - Abort voids transaction, returns to stop, alert untouched
// - Select pins re-decoded each transmission, SDA/SCL ties recognised
`timescale 1ns/1ps
`default_nettype none

module sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	logic [W-1:0] meta;
	// Data flops carry no reset so straps pass through during reset
	always_ff @(posedge clk) begin
		meta <= d;
		q    <= meta;
	end
endmodule

////////////////////////////////////////////////////////////////////////

module port_expander
	import expander_pkg::*;
#(
	// One byte per select code, code 0 in the low byte
	parameter logic [127:0] DEFAULT_LEVELS = 128'h0000_0000_0000_0000_0000_0000_0000_0000
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       abort_n,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output var  logic       sda_out,
	output var  logic       sda_oe,
	input  wire logic       addr_sel_low,
	input  wire logic       addr_sel_high,
	input  wire logic [7:0] sense_inputs,
	input  wire logic [7:0] output_sense,
	output var  logic [7:0] driven_outputs,
	output var  logic       alert_n
);

	////////////////////////////////////////////////////////////////////
	// Synchronisers
	logic [7:0] in_s;
	logic [7:0] osense_s;
	logic [4:0] pins_s;
	logic       scl_s;
	logic       sda_s;
	logic       lo_s;
	logic       hi_s;
	logic       abort_s_n;

	sync2 #(.W(8)) u_in_sync (
		.clk (clk),
		.d   (sense_inputs),
		.q   (in_s)
	);
	sync2 #(.W(8)) u_out_sync (
		.clk (clk),
		.d   (output_sense),
		.q   (osense_s)
	);
	sync2 #(.W(5)) u_pin_sync (
		.clk (clk),
		.d   ({abort_n, addr_sel_high, addr_sel_low, sda_in, scl_in}),
		.q   (pins_s)
	);

	assign scl_s     = pins_s[0];
	assign sda_s     = pins_s[1];
	assign lo_s      = pins_s[2];
	assign hi_s      = pins_s[3];
	assign abort_s_n = pins_s[4];

	////////////////////////////////////////////////////////////////////
	// Bus condition decode
	logic scl_d;
	logic sda_d;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	// Data sampled only on clock rise, so changes while high are conditions
	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign start_c  = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_c   = scl_s & scl_d & ~sda_d & sda_s;

	////////////////////////////////////////////////////////////////////
	// Address-select decode
	logic [1:0] eq_scl;
	logic [1:0] eq_sda;
	logic [1:0] hi_code;
	logic [1:0] lo_code;
	logic [1:0] hi_lvl;
	logic [1:0] lo_lvl;
	logic [6:0] addr_in;
	logic [6:0] addr_out;

	link_state_t state;

	// A pin that tracked SCL or SDA for the whole address byte is tied to it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			eq_scl <= 2'b00;
			eq_sda <= 2'b00;
		end else if (start_c) begin
			eq_scl <= 2'b11;
			eq_sda <= 2'b11;
		end else if (state == st_addr) begin
			eq_scl <= eq_scl & ~({hi_s, lo_s} ^ {scl_s, scl_s});
			eq_sda <= eq_sda & ~({hi_s, lo_s} ^ {sda_s, sda_s});
		end
	end

	assign hi_lvl   = hi_s ? HI_VPLUS : HI_GND;
	assign lo_lvl   = lo_s ? LO_VPLUS : LO_GND;
	assign hi_code  = eq_scl[1] ? HI_SCL : (eq_sda[1] ? HI_SDA : hi_lvl);
	assign lo_code  = eq_scl[0] ? LO_SCL : (eq_sda[0] ? LO_SDA : lo_lvl);
	assign addr_in  = {TOP_IN, hi_code, lo_code};
	assign addr_out = {TOP_OUT, hi_code, lo_code};

	////////////////////////////////////////////////////////////////////
	// Serial engine
	logic [3:0] bitcnt;
	logic [7:0] shreg;
	logic       rw;
	logic       grp_out;
	logic       byte_odd;
	logic       reading;
	logic       ack_rise;
	logic       do_sample;
	logic       hit_in;
	logic       hit_out;
	logic       wr_apply;
	logic [7:0] old_flags;
	logic [7:0] tx_next;
	logic [7:0] snapshot;
	logic [7:0] flags;
	logic [7:0] mask;

	assign hit_in   = shreg[7:1] == addr_in;
	assign hit_out  = shreg[7:1] == addr_out;
	// Nack from master ends the read; no new byte is loaded
	assign ack_rise = scl_rise & ((state == st_aack) | (state == st_rack)
		| ((state == st_mack) & ~sda_s));
	// Flags byte of a pair carries no resample
	assign do_sample = ack_rise & ~(rw & ~grp_out & byte_odd);
	assign wr_apply  = scl_rise & (state == st_rack);
	assign tx_next   = grp_out ? osense_s : (byte_odd ? old_flags : in_s);

	always_ff @(posedge clk) begin
		if (!rst_n || !abort_s_n) begin
			state    <= st_idle;
			bitcnt   <= BIT_ZERO;
			shreg    <= BYTE_ZERO;
			rw       <= 1'b0;
			grp_out  <= 1'b0;
			byte_odd <= 1'b0;
			reading  <= 1'b0;
			sda_oe   <= 1'b0;
		end else if (stop_c) begin
			state   <= st_idle;
			reading <= 1'b0;
			sda_oe  <= 1'b0;
		end else if (start_c) begin
			state    <= st_addr;
			bitcnt   <= BIT_ZERO;
			byte_odd <= 1'b0;
			sda_oe   <= 1'b0;
		end else begin
			case (state)
				st_addr, st_rx: begin
					if (scl_rise) begin
						shreg  <= {shreg[6:0], sda_s};
						bitcnt <= bitcnt + BIT_ONE;
					end else if (scl_fall && bitcnt == BYTE_BITS) begin
						if (state == st_rx) begin
							state  <= st_rack;
							sda_oe <= 1'b1;
						end else if (hit_in || hit_out) begin
							state   <= st_aack;
							sda_oe  <= 1'b1;
							rw      <= shreg[0];
							grp_out <= hit_out;
						end else begin
							state <= st_idle;
						end
					end
				end
				st_aack, st_rack, st_mack: begin
					if (ack_rise && (rw || state == st_mack)) begin
						shreg    <= tx_next;
						byte_odd <= ~byte_odd;
						reading  <= 1'b1;
					end else if (scl_rise && state == st_mack) begin
						// Master nack ends a read; write acks wait for the fall
						state <= st_idle;
					end else if (scl_fall) begin
						bitcnt <= BIT_ZERO;
						sda_oe <= 1'b0;
						state  <= st_rx;
						if (rw) begin
							sda_oe <= ~shreg[7];
							shreg  <= {shreg[6:0], 1'b0};
							bitcnt <= BIT_ONE;
							state  <= st_tx;
						end
					end
				end
				st_tx: begin
					if (scl_fall) begin
						if (bitcnt == BYTE_BITS) begin
							sda_oe <= 1'b0;
							state  <= st_mack;
						end else begin
							sda_oe <= ~shreg[7];
							shreg  <= {shreg[6:0], 1'b0};
							bitcnt <= bitcnt + BIT_ONE;
						end
					end
				end
				default: state <= st_idle;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// Transition detect, mask, outputs, alert
	logic [7:0] next_flags;

	// Snapshot reload takes this cycle's inputs, so a same-cycle change reaches old_flags but not flags
	assign next_flags = do_sample ? FLAGS_RESET : (flags | (in_s ^ snapshot));

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			snapshot       <= in_s;
			flags          <= FLAGS_RESET;
			old_flags      <= FLAGS_RESET;
			mask           <= MASK_RESET;
			driven_outputs <= DEFAULT_LEVELS[{hi_lvl, lo_lvl, 3'b000} +: BYTE_W];
			sda_out        <= 1'b0;
			alert_n        <= 1'b1;
		end else begin
			flags   <= next_flags;
			sda_out <= 1'b0;
			if (do_sample) begin
				snapshot  <= in_s;
				old_flags <= flags | (in_s ^ snapshot);
			end
			if (wr_apply && !grp_out) begin
				mask <= shreg;
			end
			if (wr_apply && grp_out) begin
				driven_outputs <= shreg;
			end
			// Abort leaves the alert as it stands
			if (!abort_s_n) begin
				alert_n <= alert_n;
			end else if (reading || do_sample) begin
				alert_n <= 1'b1;
			end else begin
				alert_n <= ~|(flags & mask);
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	reset_values_a: assert property (
		@(posedge clk) !rst_n |=> (mask == MASK_RESET && flags == FLAGS_RESET && alert_n))
		else $error("reset values wrong");

	read_alert_off_a: assert property (
		@(posedge clk) disable iff (!rst_n) reading |=> alert_n)
		else $error("alert asserted during read");

	flag_sticky_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		!do_sample |=> ((flags & $past(flags)) == $past(flags)))
		else $error("flag dropped without access");

	flag_set_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(!do_sample && in_s != snapshot) |=> ((flags & $past(in_s ^ snapshot)) == $past(in_s ^ snapshot)))
		else $error("change not flagged");

	mask_load_a: assert property (
		@(posedge clk) disable iff (!rst_n || !abort_s_n)
		(wr_apply && !grp_out) |=> (mask == $past(shreg) && flags == FLAGS_RESET && alert_n))
		else $error("mask write failed");

	out_load_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(wr_apply && grp_out) |=> driven_outputs == $past(shreg))
		else $error("output write failed");

	addr_ack_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		(state == st_aack && scl_s) |-> sda_oe)
		else $error("address not acknowledged");

	stop_idle_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		stop_c |=> (state == st_idle && !sda_oe))
		else $error("stop not honoured");

	flags_byte_a: assert property (
		@(posedge clk) disable iff (!rst_n || !abort_s_n)
		(ack_rise && rw && !grp_out && byte_odd && !stop_c && !start_c) |=> shreg == $past(old_flags))
		else $error("old flags not sent");

	sda_low_only_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		sda_oe |-> (!sda_out && state inside {st_aack, st_rack, st_tx, st_mack}))
		else $error("sda driven out of turn");

endmodule

`default_nettype wire

// [bus_master.sv]
// Purpose: Behavioural bus master for the expander link
// Assumes: Pulled-up lines, each clock phase 8 system clocks
// Notes:   Clock line stands high between frames
`timescale 1ns/1ps
`default_nettype none

module bus_master (
	input  wire logic clk,
	input  wire logic sda,
	output var  logic scl,
	output var  logic sda_low
);
	initial begin
		scl = 1'h1;
		sda_low = 1'h0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////
	// Framing; start also serves as a repeated start
	task automatic start();
		sda_low <= 1'h0;
		tick(4);
		scl <= 1'h1;
		tick(8);
		sda_low <= 1'h1;
		tick(8);
		scl <= 1'h0;
		tick(4);
	endtask

	task automatic stop();
		sda_low <= 1'h1;
		tick(4);
		scl <= 1'h1;
		tick(8);
		sda_low <= 1'h0;
		tick(8);
	endtask

	////////////////////////////////////////////////////////////////
	// Data moves only while clock is low
	task automatic put_bit(input logic b);
		sda_low <= ~b;
		tick(4);
		scl <= 1'h1;
		tick(8);
		scl <= 1'h0;
		tick(4);
	endtask

	task automatic get_bit(output logic b);
		sda_low <= 1'h0;
		tick(4);
		scl <= 1'h1;
		tick(4);
		b = sda;
		tick(4);
		scl <= 1'h0;
		tick(4);
	endtask

	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) put_bit(d[i]);
		get_bit(a);
		ack = ~a;
	endtask

	// Last byte left unacknowledged before stop
	task automatic rbyte(output logic [7:0] d, input logic last);
		for (int i = 7; i >= 0; i--) get_bit(d[i]);
		put_bit(last);
	endtask
endmodule

`default_nettype wire

// [i2c_port_expander_change_detect_tb.sv]
// Purpose: Self-checking bench for the port expander
// Assumes: High select pin on ground unless tied to clock, low pin on supply unless tied to data
// Notes:   Select code 9 carries a non-zero power-up level
`timescale 1ns/1ps
`default_nettype none

module i2c_port_expander_change_detect_tb
	import expander_pkg::*;
;
	localparam logic [6:0] IN_A  = {TOP_IN, HI_GND, LO_VPLUS};
	localparam logic [6:0] OUT_A = {TOP_OUT, HI_GND, LO_VPLUS};
	localparam logic [6:0] SDA_A = {TOP_IN, HI_GND, LO_SDA};

	logic       clk = 1'h0;
	logic       rst_n;
	logic       abort_n;
	logic       lo_sda;
	logic       hi_scl;
	logic [7:0] sense;
	logic [7:0] osense;
	logic [7:0] dout;
	logic [7:0] d0, d1, d2, d3;
	logic       scl, m_low, sda_oe, sda_out, alert_n;
	wire        sda;
	wire        sel_low;
	wire        sel_high;
	int         miscompares = 0;
	int         n_tests = 0;

	// Open drain: either party only pulls low
	assign sda = ~((sda_oe & ~sda_out) | m_low);
	assign sel_low = lo_sda ? sda : 1'h1;
	assign sel_high = hi_scl ? scl : 1'h0;

	always #50 clk = ~clk;

	port_expander #(.DEFAULT_LEVELS(128'h0000_0000_0000_3C00_0000_0000_0000_0000)) DUT (
		.clk(clk), .rst_n(rst_n), .abort_n(abort_n), .scl_in(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe(sda_oe), .addr_sel_low(sel_low), .addr_sel_high(sel_high),
		.sense_inputs(sense), .output_sense(osense), .driven_outputs(dout), .alert_n(alert_n));

	bus_master master (.clk(clk), .sda(sda), .scl(scl), .sda_low(m_low));

	////////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic send(input logic [7:0] d, input logic exp_ack);
		logic ack;
		master.wbyte(d, ack);
		chk("ack", {7'h00, exp_ack}, {7'h00, ack});
	endtask

	task automatic results();
		if (miscompares == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Bound on the whole run
	initial begin
		repeat (100000) @(posedge clk);
		miscompares++;
		results();
	end

	////////////////////////////////////////////////////////////////
	initial begin
		rst_n = 1'h0;
		abort_n = 1'h1;
		lo_sda = 1'h0;
		hi_scl = 1'h0;
		sense = 8'h00;
		osense = 8'hC3;
		repeat (3) @(posedge clk);
		rst_n <= 1'h1;
		master.tick(3);
		chk("outputs", 8'h3C, dout);
		chk("alert", 8'h01, {7'h00, alert_n});
		master.start();
		send({OUT_A, 1'h0}, 1'h1);
		send(8'hA5, 1'h1);
		chk("outputs", 8'hA5, dout);
		send(8'h5A, 1'h1);
		chk("outputs", 8'h5A, dout);
		master.stop();
		// Readback must be resampled at every acknowledge
		master.start();
		send({OUT_A, 1'h1}, 1'h1);
		fork
			master.rbyte(d0, 1'h0);
			begin
				master.tick(40);
				osense <= 8'h3C;
			end
		join
		master.rbyte(d1, 1'h1);
		master.stop();
		chk("readback", 8'hC3, d0);
		chk("readback", 8'h3C, d1);
		master.start();
		send({IN_A, 1'h0}, 1'h1);
		send(8'h01, 1'h1);
		master.stop();
		sense <= 8'h02;
		master.tick(20);
		chk("alert", 8'h01, {7'h00, alert_n});
		sense <= 8'h00;
		master.tick(20);
		master.start();
		send({IN_A, 1'h1}, 1'h1);
		master.rbyte(d0, 1'h0);
		master.rbyte(d1, 1'h1);
		master.stop();
		chk("inputs", 8'h00, d0);
		chk("flags", 8'h02, d1);
		sense <= 8'h01;
		master.tick(20);
		chk("alert", 8'h00, {7'h00, alert_n});
		master.start();
		send({IN_A, 1'h0}, 1'h1);
		chk("alert", 8'h01, {7'h00, alert_n});
		send(8'hFF, 1'h1);
		master.stop();
		// Change inside a read is held back until stop
		master.start();
		send({IN_A, 1'h1}, 1'h1);
		sense <= 8'h00;
		master.rbyte(d0, 1'h1);
		chk("alert", 8'h01, {7'h00, alert_n});
		master.stop();
		master.tick(10);
		chk("alert", 8'h00, {7'h00, alert_n});
		chk("inputs", 8'h01, d0);
		master.start();
		send({IN_A, 1'h1}, 1'h1);
		fork
			master.rbyte(d0, 1'h0);
			begin
				master.tick(40);
				sense <= 8'h04;
			end
		join
		master.rbyte(d1, 1'h0);
		master.rbyte(d2, 1'h0);
		master.rbyte(d3, 1'h1);
		master.stop();
		master.tick(10);
		chk("inputs", 8'h00, d0);
		chk("flags", 8'h01, d1);
		chk("inputs", 8'h04, d2);
		chk("flags", 8'h04, d3);
		chk("alert", 8'h01, {7'h00, alert_n});
		master.start();
		send({3'h7, HI_GND, LO_VPLUS, 1'h0}, 1'h0);
		master.stop();
		lo_sda <= 1'h1;
		master.start();
		send({IN_A, 1'h1}, 1'h0);
		master.stop();
		master.start();
		send({SDA_A, 1'h0}, 1'h1);
		send(8'hFF, 1'h1);
		master.stop();
		lo_sda <= 1'h0;
		// High select pin tied to the clock line
		hi_scl <= 1'h1;
		master.start();
		send({TOP_IN, HI_SCL, LO_VPLUS, 1'h0}, 1'h1);
		send(8'hFF, 1'h1);
		master.stop();
		hi_scl <= 1'h0;
		// Abort in mid-byte: byte is lost, no acknowledge
		master.start();
		send({OUT_A, 1'h0}, 1'h1);
		send(8'h11, 1'h1);
		fork
			send(8'h22, 1'h0);
			begin
				master.tick(20);
				abort_n <= 1'h0;
				master.tick(10);
				abort_n <= 1'h1;
			end
		join
		master.stop();
		chk("outputs", 8'h11, dout);
		results();
	end
endmodule

`default_nettype wire
